// ===== ueh_pkg.sv
// Shared constants and types of the host endpoint configuration block
package ueh_pkg;
  localparam int NEP = 4;
  localparam int NSLOT = 2 * NEP;
  localparam int EPW = 2;
  localparam int SLW = 3;
  localparam int ADW = 7;
  localparam int REPW = 4;
  localparam int MPW = 11;
  localparam int IVW = 8;
  localparam int CNW = 16;
  localparam logic [IVW-1:0] NAK_LIMIT_DISABLE = 8'h00;
  localparam logic [IVW-1:0] NAK_LIMIT_MAX = 8'h10;
  localparam logic PING_EN_RST = 1'b1;
  localparam logic TOGGLE_RST = 1'b0;
  localparam logic DIR_IN = 1'b1;

  typedef enum logic [1:0] {
    type_control_transfer,
    type_isochronous_transfer,
    type_bulk_transfer,
    type_interrupt_transfer
  } ueh_type_t;

  typedef struct packed {
    logic [REPW-1:0] remote_endpoint_number;
    ueh_type_t       typ;
    logic            speed_low_select;
    logic [MPW-1:0]  max_packet_bytes;
    logic [IVW-1:0]  timeout_or_poll_interval;
    logic            auto_go;
    logic            in_auto_clear_packet_ready;
  } ueh_cfg_t;

  typedef struct packed {
    logic [ADW-1:0]  target_function_address;
    logic [REPW-1:0] remote_endpoint_number;
    ueh_type_t       typ;
    logic            speed_low_select;
    logic            toggle;
    logic            ping_en;
  } ueh_tok_t;
endpackage

// ===== ueh_ep_cfg.sv
// Host endpoint configuration, frame timing and automatic FIFO control
//
// Notes on behaviour
// R1: Each endpoint IN and OUT portion keeps its own readable target address.
// R2: Each portion selects control, isochronous, bulk or interrupt transfer type.
// R3: Endpoint zero and bulk portions use the interval field as NAK timeout.
// R4: NAK timeout code n allows two to the n minus one frames.
// R5: Interrupt portions poll every n frames, n from one to 255.
// R6: Isochronous portions poll every two to the n minus one frames.
// R7: A disable code turns NAK timeout detection off entirely.
// R8: Auto send starts OUT transfer once FIFO holds a full payload.
// R9: Auto request issues next IN once FIFO has room for a payload.
// R10: Auto clear drops packet ready once packet data is read out.
// R11: Without auto clear software clears packet ready after reading data.
// R12: Data acknowledge marks the FIFO packet consumed and frees it.
// R13: Software forces DATA0 or DATA1 on a chosen portion.
// R14: Endpoint zero has one shared toggle; direction is ignored.
// R15: Endpoint zero control bit enables or suppresses PING tokens.
// R16: Each portion has its own full or low speed setting.
// R17: IN and OUT portions are configured independently.
// R18: Each endpoint holds the remote endpoint number placed in tokens.
// R19: Software uses these controls only in host mode.
// R20: The NAK timeout field has a largest accepted maximum code.
// R21: NAK frame count restarts on non NAK response or new transfer, unless a frame tick in the same cycle updates it.
`timescale 1ns/10ps
module ueh_ep_cfg
  import ueh_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic [EPW-1:0]            sw_ep,
  input  wire logic                      sw_dir,
  input  wire logic                      sw_addr_we,
  input  wire logic [ADW-1:0]            sw_addr,
  input  wire logic                      sw_cfg_we,
  input  wire ueh_cfg_t                  sw_cfg,
  input  wire logic                      sw_spd_we,
  input  wire logic                      sw_spd_low,
  input  wire logic                      sw_tog_we,
  input  wire logic                      toggle_state_select,
  input  wire logic                      sw_ping_we,
  input  wire logic                      sw_ping_val,
  input  wire logic                      sw_pkt_clr,
  input  wire logic                      sw_ack,
  input  wire logic                      frame_tick,
  input  wire logic [EPW-1:0]            eng_ep,
  input  wire logic                      eng_dir,
  input  wire logic                      eng_xfer_start,
  input  wire logic                      eng_resp,
  input  wire logic                      eng_nak,
  input  wire logic                      eng_tog_flip,
  input  wire logic                      eng_rx_done,
  input  wire logic                      eng_tx_done,
  input  wire logic [NEP-1:0]            fifo_read_done,
  input  wire logic [NEP-1:0][MPW-1:0]   out_level,
  input  wire logic [NEP-1:0][MPW-1:0]   in_free,
  output logic [ADW-1:0]                 rd_addr_r,
  output ueh_cfg_t                       rd_cfg_r,
  output logic                           rd_tog_r,
  output ueh_tok_t                       tok_r,
  output logic [NSLOT-1:0]               nak_to_r,
  output logic [NSLOT-1:0]               poll_due_r,
  output logic [NEP-1:0]                 pkt_ready_r,
  output logic [NEP-1:0]                 fifo_release_r,
  output logic [NEP-1:0]                 out_start_r,
  output logic [NEP-1:0]                 in_req_r,
  output logic                           ping_en_r
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [SLW-1:0] slot(input logic [EPW-1:0] ep, input logic dir);
    slot = {ep, dir};
  endfunction

  // Endpoint zero shares one toggle for both directions
  function automatic logic [SLW-1:0] tslot(input logic [EPW-1:0] ep, input logic dir);
    tslot = (ep == '0) ? '0 : {ep, dir}; // [R14]
  endfunction

  // Two to the power n minus one, code zero read as one frame
  function automatic logic [CNW-1:0] pow_frames(input logic [IVW-1:0] n);
    logic [IVW-1:0] c;
    c = (n > NAK_LIMIT_MAX) ? NAK_LIMIT_MAX : n; // [R20]
    if (c == '0) begin
      pow_frames = 16'h0001;
    end else begin
      pow_frames = 16'h0001 << (c - 8'h01); // [R4] [R6]
    end
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_r;
  logic rst_n;

  // Two stage release of the asynchronous reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // ****************************************************************
  // Configuration storage
  // ****************************************************************
  logic [NSLOT-1:0][ADW-1:0] addr_r;
  ueh_cfg_t [NSLOT-1:0]      cfg_r;
  logic [NSLOT-1:0]          tog_r;
  logic [NSLOT-1:0][CNW-1:0] cnt_r;
  logic [NSLOT-1:0]          nak_seen_r;
  logic [NEP-1:0]            tx_pend_r;
  logic [NEP-1:0]            rx_pend_r;
  logic [SLW-1:0]            sws;
  logic [SLW-1:0]            egs;

  assign sws = slot(sw_ep, sw_dir);
  assign egs = slot(eng_ep, eng_dir);

  // Function address per portion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= '0;
    end else if (sw_addr_we) begin
      addr_r[sws] <= sw_addr; // [R1] [R17]
    end
  end

  // Portion configuration, speed may be changed on its own
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= '0;
    end else begin
      if (sw_cfg_we) begin
        cfg_r[sws] <= sw_cfg; // [R2] [R17] [R18]
      end
      if (sw_spd_we) begin
        cfg_r[sws].speed_low_select <= sw_spd_low; // [R16]
      end
    end
  end

  // Data toggle, a forced value beats a flip in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tog_r <= {NSLOT{TOGGLE_RST}};
    end else begin
      if (eng_tog_flip) begin
        tog_r[tslot(eng_ep, eng_dir)] <= ~tog_r[tslot(eng_ep, eng_dir)];
      end
      if (sw_tog_we) begin
        tog_r[tslot(sw_ep, sw_dir)] <= toggle_state_select; // [R13] [R14]
      end
    end
  end

  // PING token enable, endpoint zero only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ping_en_r <= PING_EN_RST;
    end else if (sw_ping_we && sw_ep == '0) begin
      ping_en_r <= sw_ping_val; // [R15]
    end
  end

  // ****************************************************************
  // Readback and token fields
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_r <= '0;
      rd_cfg_r  <= '0;
      rd_tog_r  <= 1'b0;
      tok_r     <= '0;
    end else begin
      rd_addr_r                     <= addr_r[sws]; // [R1]
      rd_cfg_r                      <= cfg_r[sws];
      rd_tog_r                      <= tog_r[tslot(sw_ep, sw_dir)];
      tok_r.target_function_address <= addr_r[egs]; // [R1]
      tok_r.remote_endpoint_number  <= cfg_r[egs].remote_endpoint_number; // [R18]
      tok_r.typ                     <= cfg_r[egs].typ;
      tok_r.speed_low_select        <= cfg_r[egs].speed_low_select; // [R16]
      tok_r.toggle                  <= tog_r[tslot(eng_ep, eng_dir)];
      tok_r.ping_en                 <= (eng_ep == '0) && ping_en_r; // [R15]
    end
  end

  // ****************************************************************
  // Frame counters: NAK timeout or polling interval
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r      <= '0;
      nak_seen_r <= '0;
      nak_to_r   <= '0;
      poll_due_r <= '0;
    end else begin
      poll_due_r <= '0;
      for (int i = 0; i < NSLOT; i++) begin
        // New transfer or any non NAK answer restarts the count, except in a cycle where a frame tick updates it
        if (eng_xfer_start && egs == SLW'(i)) begin
          cnt_r[i]      <= '0; // [R21]
          nak_seen_r[i] <= 1'b0;
          nak_to_r[i]   <= 1'b0;
        end
        if (eng_resp && egs == SLW'(i)) begin
          nak_seen_r[i] <= eng_nak;
          if (!eng_nak) begin
            cnt_r[i] <= '0; // [R21]
          end
        end
        if (frame_tick) begin
          if (i >= 2 && cfg_r[i].typ == type_interrupt_transfer) begin
            // Interrupt interval is taken directly in frames
            if ({8'h00, cfg_r[i].timeout_or_poll_interval} <= cnt_r[i] + 16'h0001) begin
              cnt_r[i]      <= '0; // [R5]
              poll_due_r[i] <= 1'b1;
            end else begin
              cnt_r[i] <= cnt_r[i] + 16'h0001;
            end
          end else if (i >= 2 && cfg_r[i].typ == type_isochronous_transfer) begin
            if (pow_frames(cfg_r[i].timeout_or_poll_interval) <= cnt_r[i] + 16'h0001) begin
              cnt_r[i]      <= '0; // [R6]
              poll_due_r[i] <= 1'b1;
            end else begin
              cnt_r[i] <= cnt_r[i] + 16'h0001;
            end
          end else if (nak_seen_r[i] && !nak_to_r[i] &&
                       cfg_r[i].timeout_or_poll_interval != NAK_LIMIT_DISABLE) begin // [R7]
            // Endpoint zero and bulk: count frames of NAKs
            if (pow_frames(cfg_r[i].timeout_or_poll_interval) <= cnt_r[i] + 16'h0001) begin
              nak_to_r[i] <= 1'b1; // [R3] [R4]
            end else begin
              cnt_r[i] <= cnt_r[i] + 16'h0001;
            end
          end
        end
      end
    end
  end

  // ****************************************************************
  // Packet ready, acknowledge and automatic FIFO control
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pkt_ready_r    <= '0;
      fifo_release_r <= '0;
    end else begin
      fifo_release_r <= '0;
      for (int e = 0; e < NEP; e++) begin
        // Software clear, acknowledge or auto clear; a new packet wins
        if (sw_pkt_clr && sw_ep == EPW'(e)) begin
          pkt_ready_r[e] <= 1'b0; // [R11]
        end
        if (fifo_read_done[e] && cfg_r[2*e+1].in_auto_clear_packet_ready) begin
          pkt_ready_r[e] <= 1'b0; // [R10]
        end
        if (sw_ack && sw_ep == EPW'(e)) begin
          pkt_ready_r[e]    <= 1'b0; // [R12]
          fifo_release_r[e] <= 1'b1;
        end
        if (eng_rx_done && eng_ep == EPW'(e)) begin
          pkt_ready_r[e] <= 1'b1;
        end
      end
    end
  end

  // Automatic OUT start and IN request, one pulse per pending transfer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_pend_r   <= '0;
      rx_pend_r   <= '0;
      out_start_r <= '0;
      in_req_r    <= '0;
    end else begin
      out_start_r <= '0;
      in_req_r    <= '0;
      for (int e = 0; e < NEP; e++) begin
        if (eng_tx_done && eng_ep == EPW'(e)) begin
          tx_pend_r[e] <= 1'b0;
        end
        if (eng_rx_done && eng_ep == EPW'(e)) begin
          rx_pend_r[e] <= 1'b0;
        end
        if (cfg_r[2*e].auto_go && !tx_pend_r[e] &&
            out_level[e] >= cfg_r[2*e].max_packet_bytes) begin
          out_start_r[e] <= 1'b1; // [R8]
          tx_pend_r[e]   <= 1'b1;
        end
        if (cfg_r[2*e+1].auto_go && !rx_pend_r[e] && !pkt_ready_r[e] &&
            in_free[e] >= cfg_r[2*e+1].max_packet_bytes) begin
          in_req_r[e]  <= 1'b1; // [R9]
          rx_pend_r[e] <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== ueh_ep_cfg_sva.sv
// Port assertions for the host endpoint configuration block
`timescale 1ns/10ps
module ueh_ep_cfg_sva
  import ueh_pkg::*;
(
  input wire logic             clock,
  input wire logic             resetn,
  input wire logic [EPW-1:0]   sw_ep,
  input wire logic             sw_ping_we,
  input wire logic             sw_ping_val,
  input wire logic             sw_ack,
  input wire logic             sw_pkt_clr,
  input wire logic             frame_tick,
  input wire logic [EPW-1:0]   eng_ep,
  input wire logic             eng_dir,
  input wire logic             eng_xfer_start,
  input wire logic             eng_rx_done,
  input wire logic [NSLOT-1:0] nak_to_r,
  input wire logic [NSLOT-1:0] poll_due_r,
  input wire logic [NEP-1:0]   pkt_ready_r,
  input wire logic [NEP-1:0]   fifo_release_r,
  input wire logic [NEP-1:0]   out_start_r,
  input wire logic             ping_en_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Ping enable, release pulse and packet ready
  property p_ping_off; sw_ping_we && sw_ep == 0 && !sw_ping_val |-> ##[1:2] !ping_en_r; endproperty
  a_ping_off: assert property (p_ping_off) else $error("ping enable not cleared");
  property p_rel; sw_ack |=> fifo_release_r[$past(sw_ep)]; endproperty
  a_rel: assert property (p_rel) else $error("no release after ack");
  property p_rdy_set; eng_rx_done |=> pkt_ready_r[$past(eng_ep)]; endproperty
  a_rdy_set: assert property (p_rdy_set) else $error("packet ready not set");
  property p_rdy_clr; sw_pkt_clr && !eng_rx_done |=> !pkt_ready_r[$past(sw_ep)]; endproperty
  a_rdy_clr: assert property (p_rdy_clr) else $error("packet ready not cleared");
  // Frame driven timeout and polling, single cycle OUT start pulse and covers
  property p_nak_clr;
    eng_xfer_start && eng_ep != 0 && !frame_tick |=> !nak_to_r[{$past(eng_ep), $past(eng_dir)}];
  endproperty
  a_nak_clr: assert property (p_nak_clr) else $error("timeout kept after start");
  property p_nak_tick;
    (nak_to_r & ~$past(nak_to_r)) != 0 |-> $past(frame_tick) || $past(frame_tick, 2);
  endproperty
  a_nak_tick: assert property (p_nak_tick) else $error("timeout without frame");
  property p_poll_tick; poll_due_r != 0 |-> $past(frame_tick) || $past(frame_tick, 2); endproperty
  a_poll_tick: assert property (p_poll_tick) else $error("poll without frame");
  property p_out_pulse; (out_start_r & $past(out_start_r)) == 0; endproperty
  a_out_pulse: assert property (p_out_pulse) else $error("start held two cycles");
  cover property (nak_to_r != 0);
  cover property (poll_due_r != 0);
  cover property (fifo_release_r != 0);
endmodule
bind ueh_ep_cfg ueh_ep_cfg_sva u_sva (.*);

// ===== ueh_dev_model.sv
// Behavioural model of the device answering host transfers
`timescale 1ns/10ps
module ueh_dev_model
  import ueh_pkg::*;
#(
  parameter int DLY = 3
)
(
  input  wire logic           clock,
  input  wire logic [NEP-1:0] out_start_r,
  input  wire logic [NEP-1:0] in_req_r,
  input  wire logic           nak_req,
  output logic                eng_resp = 1'b0,
  output logic                eng_nak = 1'b0,
  output logic                eng_tx_done = 1'b0,
  output logic                eng_rx_done = 1'b0
);
  int tx_n = 0;
  int rx_n = 0;
  // Finish each started transfer DLY cycles later; NAK on command
  always @(posedge clock) begin
    eng_resp <= nak_req;
    eng_nak <= nak_req | ~eng_nak; // Churns while no answer stands
    eng_tx_done <= (tx_n == 1);
    eng_rx_done <= (rx_n == 1);
    tx_n <= |out_start_r ? DLY : (tx_n > 0 ? tx_n - 1 : 0);
    rx_n <= |in_req_r ? DLY : (rx_n > 0 ? rx_n - 1 : 0);
  end
endmodule

// ===== ueh_ep_cfg_tb.sv
// Self-checking bench of the host endpoint configuration block
`timescale 1ns/10ps
module ueh_ep_cfg_tb
  import ueh_pkg::*;
();
  logic clock = 0, resetn = 0, sw_dir = 0, sw_addr_we = 0, sw_cfg_we = 0, sw_spd_we = 0;
  logic sw_spd_low = 0, sw_tog_we = 0, toggle_state_select = 0, sw_ping_we = 0;
  logic sw_ping_val = 0, sw_pkt_clr = 0, sw_ack = 0, frame_tick = 0, eng_dir = 0;
  logic eng_xfer_start = 0, eng_tog_flip = 0, nak_req = 0, eng_resp, eng_nak;
  logic eng_rx_done, eng_tx_done, rd_tog_r, ping_en_r;
  logic [EPW-1:0] sw_ep = '0, eng_ep = '0;
  logic [ADW-1:0] sw_addr = '0, rd_addr_r;
  ueh_cfg_t sw_cfg = '0, rd_cfg_r, c;
  ueh_tok_t tok_r;
  logic [NSLOT-1:0] nak_to_r, poll_due_r;
  logic [NEP-1:0] fifo_read_done = '0, pkt_ready_r, fifo_release_r, out_start_r, in_req_r;
  logic [NEP-1:0][MPW-1:0] out_level = '0, in_free = '0;
  logic [ADW-1:0] ea [NSLOT];
  ueh_cfg_t ec [NSLOT];
  int fail_count = 0, checks = 0, cycles = 0, n_out = 0, n_in = 0, n_rel = 0, m;

  ueh_ep_cfg dut (.*);
  ueh_dev_model partner (.*);

  always #12.5 clock = ~clock;
  // Cycle ceiling and pulse counters of endpoint 1
  always @(posedge clock) begin
    cycles++;
    n_out += out_start_r[1];
    n_in += in_req_r[1];
    n_rel += fifo_release_r[1];
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int k = 1);
    repeat (k) @(negedge clock);
  endtask
  task automatic pul(ref logic s);
    s = 1;
    cyc();
    s = 0;
  endtask
  task automatic sel(int e, int d);
    sw_ep = EPW'(e);
    sw_dir = d[0];
  endtask
  task automatic wcfg(int e, int d, ueh_cfg_t v);
    sel(e, d);
    sw_cfg = v;
    pul(sw_cfg_we);
  endtask
  // Frames between events for a code of the interval field
  function automatic int frames(ueh_type_t t, int v);
    return t == type_interrupt_transfer ? v : 1 << (v - 1);
  endfunction
  // Distance between two poll pulses of slot s with a frame every cycle
  task automatic per(int s, int e);
    int k;
    k = 0;
    frame_tick = 1;
    while (poll_due_r[s] !== 1'b1 && k < 600) begin cyc(); k++; end
    k = 0;
    do begin cyc(); k++; end while (poll_due_r[s] !== 1'b1 && k < 300);
    frame_tick = 0;
    chk("poll period", k, e);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    void'($urandom(33)); // Controls are driven as in host mode only
    cyc(20);
    resetn = 1;
    cyc(4);
    chk("ping reset", ping_en_r, PING_EN_RST);
    for (int s = 0; s < NSLOT; s++) begin
      ea[s] = ADW'($urandom);
      ec[s] = ueh_cfg_t'($bits(ueh_cfg_t)'($urandom));
      ec[s].auto_go = 0;
      sw_addr = ea[s]; sw_addr_we = 1; wcfg(s >> 1, s, ec[s]); sw_addr_we = 0;
    end
    for (int s = 0; s < NSLOT; s++) begin
      sel(s >> 1, s); eng_ep = EPW'(s >> 1); eng_dir = s[0]; cyc(2);
      chk("addr", rd_addr_r, ea[s]);
      chk("cfg", rd_cfg_r, ec[s]);
      chk("toggle", rd_tog_r, TOGGLE_RST);
      chk("token ep", tok_r.remote_endpoint_number, ec[s].remote_endpoint_number);
    end
    for (int t = 0; t < 4; t++) begin
      c = ec[6]; c.typ = ueh_type_t'(t); c.speed_low_select = t[0];
      wcfg(3, 0, c); sw_spd_low = t[0]; pul(sw_spd_we); cyc(2);
      chk("type speed", rd_cfg_r, c);
    end
    $display("test config done");
    sel(1, 1); toggle_state_select = 1; pul(sw_tog_we); cyc(2);
    chk("toggle in", rd_tog_r, 1);
    sel(1, 0); cyc(2);
    chk("toggle out", rd_tog_r, 0);
    sel(0, 0); pul(sw_tog_we); sel(0, 1); cyc(2);
    chk("toggle ep0", rd_tog_r, 1);
    eng_ep = 1; eng_dir = 1; sel(1, 1); pul(eng_tog_flip); cyc(2);
    chk("toggle flip", rd_tog_r, 0);
    sel(1, 0); pul(sw_ping_we); cyc(2);
    chk("ping refused", ping_en_r, 1);
    sel(0, 0); eng_ep = 0; pul(sw_ping_we); cyc(2);
    chk("ping off", tok_r.ping_en, 0);
    sw_ping_val = 1; pul(sw_ping_we); cyc(2);
    chk("ping on", tok_r.ping_en, 1);
    $display("test toggle ping done");
    eng_ep = 1; eng_dir = 0;
    for (int v = 0; v <= 4; v++) begin
      c = '0; c.typ = type_bulk_transfer; c.timeout_or_poll_interval = IVW'(v);
      wcfg(1, 0, c); pul(eng_xfer_start); pul(nak_req); cyc();
      m = v == 0 ? 200 : frames(c.typ, v) - 1;
      if (m > 0) begin frame_tick = 1; cyc(m); frame_tick = 0; cyc(); end
      chk("nak early", nak_to_r[2], 0);
      pul(frame_tick); cyc();
      chk("nak limit", nak_to_r[2], v != 0);
    end
    pul(eng_xfer_start); cyc();
    chk("nak restart", nak_to_r[2], 0);
    for (int v = 1; v <= 4; v++) begin
      c = '0; c.typ = v[0] ? type_interrupt_transfer : type_isochronous_transfer;
      c.timeout_or_poll_interval = v == 3 ? 8'hff : IVW'(v[0] ? 1 + $urandom % 12 : v);
      wcfg(2, 1, c); per(5, frames(c.typ, c.timeout_or_poll_interval));
    end
    $display("test frames done");
    m = 1 + $urandom % 64;
    c = '0; c.max_packet_bytes = MPW'(m); c.auto_go = 1;
    wcfg(1, 0, c); out_level[1] = MPW'(m - 1); cyc(6);
    chk("no start", n_out, 0);
    out_level[1] = MPW'(m); cyc(2); out_level[1] = '0; cyc(6);
    chk("start", n_out, 1);
    for (int a = 1; a >= 0; a--) begin
      c.in_auto_clear_packet_ready = a[0]; eng_dir = 1;
      wcfg(1, 1, c); in_free[1] = MPW'(m - 1); cyc(6);
      chk("no request", n_in, 1 - a);
      in_free[1] = MPW'(m); cyc(2); in_free[1] = '0; cyc(6);
      chk("request", n_in, 2 - a);
      chk("ready set", pkt_ready_r[1], 1);
      fifo_read_done = 4'h2; cyc(); fifo_read_done = '0; cyc();
      chk("auto clear", pkt_ready_r[1], 1 - a);
    end
    sel(1, 0); pul(sw_pkt_clr); cyc();
    chk("manual clear", pkt_ready_r[1], 0);
    pul(sw_ack); cyc(2);
    chk("release", n_rel, 1);
    $display("test auto done");
    print_verdict();
  end
endmodule
